// ===== design/cass_defines.vh
// constants for the current select, offset and scale path
`ifndef CASS_DEFINES_VH
`define CASS_DEFINES_VH

// raw source selector codes
`define CASS_SRC_IU      3'h0
`define CASS_SRC_IV      3'h1
`define CASS_SRC_SW0     3'h2
`define CASS_SRC_SW1     3'h3
`define CASS_SRC_CMP     3'h4

// output route codes
`define CASS_RT_P0       2'h0
`define CASS_RT_P1       2'h1
`define CASS_RT_THIRD    2'h2

// arithmetic
`define CASS_Q88_SHIFT   8
`define CASS_S16_MAX     16'h7FFF
`define CASS_S16_MIN     16'h8000
`define CASS_RAW_FULL    16'hFFFF
`define CASS_RAW_MID     16'h7FFF

// reset values
`define CASS_RST_CUR     16'h0000
`define CASS_RST_CMP     16'h0000

// buffering and comparator window
`define CASS_FIFO_DEPTH  8
`define CASS_CMP_WIN_LOG 8

`endif

// ===== design/cass_fifo.v
// synchronous valid/ready fifo for raw sample pairs
`default_nettype none

module cass_fifo #(
    parameter WIDTH = 32,                 // word width
    parameter DEPTH = 8,                  // number of words
    parameter AW    = 3                   // log2 of depth
) (
    input  wire             clk_i,        // system clock
    input  wire             reset_i,      // async reset, high
    input  wire [WIDTH-1:0] in_data_i,    // word to store
    input  wire             in_valid_i,   // word offered
    output wire             in_ready_o,   // room for a word
    output wire [WIDTH-1:0] out_data_o,   // oldest word
    output wire             out_valid_o,  // fifo not empty
    input  wire             out_ready_i   // drain side takes word
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];    // storage array
    reg [AW:0]      wr_ptr_q;             // write pointer with wrap bit
    reg [AW:0]      rd_ptr_q;             // read pointer with wrap bit

    wire empty = (wr_ptr_q == rd_ptr_q);  // pointers equal
    wire full  = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) &&
                 (wr_ptr_q[AW] != rd_ptr_q[AW]); // wrap bits differ
    wire push  = in_valid_i && !full;     // accepted write
    wire pop   = out_ready_i && !empty;   // accepted read

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_q[rd_ptr_q[AW-1:0]];

    // storage write, no reset needed on data
    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
        end
    end

    // pointer update
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

endmodule // cass_fifo

`default_nettype wire

// ===== design/cass_top.v
// current select, offset removal, scaling, kirchhoff and routing path
`include "cass_defines.vh"
`default_nettype none

// one clock, async high reset
// results leave by valid/ready
module cass_top #(
    parameter RAW_W   = 16,                     // converter result width
    parameter WIN_LOG = `CASS_CMP_WIN_LOG,      // log2 comparator window
    parameter DEPTH   = `CASS_FIFO_DEPTH,       // fifo words
    parameter AW      = 3                       // log2 of depth
) (
    input  wire             clk_i,              // 10 MHz system clock
    input  wire             reset_i,            // async reset, high

    // converter engine side
    input  wire [RAW_W-1:0] adc_iu_raw_i,       // phase U converter result
    input  wire [RAW_W-1:0] adc_iv_raw_i,       // phase V converter result
    input  wire             adc_valid_i,        // sample pair offered
    output wire             adc_ready_o,        // fifo can take pair
    input  wire             cmp_bit_i,          // comparator bitstream pin

    // configuration
    input  wire [2:0]       path0_source_sel_i, // path 0 source
    input  wire [2:0]       path1_source_sel_i, // path 1 source
    input  wire [15:0]      path0_sw_value_i,   // software value 0
    input  wire [15:0]      path1_sw_value_i,   // software value 1
    input  wire [15:0]      path0_offset_i,     // path 0 offset, unsigned
    input  wire [15:0]      path1_offset_i,     // path 1 offset, unsigned
    input  wire [15:0]      path0_gain_q8_8_i,  // path 0 gain, signed q8.8
    input  wire [15:0]      path1_gain_q8_8_i,  // path 1 gain, signed q8.8
    input  wire             three_phase_mode_i, // 1 three-phase, 0 two-phase
    input  wire [1:0]       ux_route_sel_i,     // UX route
    input  wire [1:0]       v_route_sel_i,      // V route
    input  wire [1:0]       wy_route_sel_i,     // WY route

    // readback
    output reg  [15:0]      adc_iu_rd_o,        // widened U channel
    output reg  [15:0]      adc_iv_rd_o,        // widened V channel
    output reg  [15:0]      cmp_raw_o,          // demodulated comparator value
    output reg  [15:0]      path0_raw_sample_o, // selected raw, path 0
    output reg  [15:0]      path1_raw_sample_o, // selected raw, path 1
    output reg  [15:0]      path0_scaled_current_o, // scaled path 0
    output reg  [15:0]      path1_scaled_current_o, // scaled path 1
    output reg  [15:0]      derived_third_current_o, // kirchhoff result
    output reg              sat_flag_o,         // last result saturated

    // control engine side
    output reg  [15:0]      phase_ux_current_o, // U / X current
    output reg  [15:0]      phase_v_current_o,  // V current
    output reg  [15:0]      phase_wy_current_o, // W / Y current
    output reg              cur_valid_o,        // currents offered
    input  wire             foc_ready_i         // control engine takes them
);

    // clamp a 26-bit signed value into s16
    // bit 16 marks a clamp
    // feeds sat_flag_o
    function [16:0] cass_sat;                   // {saturated, value}
        input [25:0] v;
        begin
            // signed test on both limits
            if ($signed(v) > $signed(26'h0007FFF)) begin
                cass_sat = {1'b1, `CASS_S16_MAX};
            end else if ($signed(v) < $signed(26'h3FF8000)) begin
                cass_sat = {1'b1, `CASS_S16_MIN};
            end else begin
                cass_sat = {1'b0, v[15:0]};
            end
        end
    endfunction

    // pick the raw value for one path
    // codes 5 to 7 read zero
    function [15:0] cass_pick;
        input [2:0]  sel;
        input [15:0] iu;
        input [15:0] iv;
        input [15:0] sw0;
        input [15:0] sw1;
        input [15:0] cmpv;
        begin
            case (sel)
                `CASS_SRC_IU:  cass_pick = iu;
                `CASS_SRC_IV:  cass_pick = iv;
                `CASS_SRC_SW0: cass_pick = sw0;
                `CASS_SRC_SW1: cass_pick = sw1;
                `CASS_SRC_CMP: cass_pick = cmpv;
                default:       cass_pick = 16'h0000;        // unused codes
            endcase
        end
    endfunction

    // offset removal and q8.8 scaling with clamp
    // product kept exact
    // before the shift
    function [16:0] cass_scale;                 // {saturated, value}
        input [15:0] raw;
        input [15:0] ofs;
        input [15:0] gain;
        reg   [16:0] diff;
        reg   [32:0] prod;
        begin
            // unsigned minus unsigned into signed 17 bits
            diff = {1'b0, raw} - {1'b0, ofs};
            prod = $signed(diff) * $signed(gain);
            // divide by 256 as an arithmetic shift
            cass_scale = cass_sat({prod[32], prod[32:`CASS_Q88_SHIFT]});
        end
    endfunction

    // route one of three currents to an output
    // code 3 reads zero
    function [15:0] cass_route;
        input [1:0]  sel;
        input [15:0] c0;
        input [15:0] c1;
        input [15:0] c2;
        begin
            case (sel)
                `CASS_RT_P0:    cass_route = c0;
                `CASS_RT_P1:    cass_route = c1;
                `CASS_RT_THIRD: cass_route = c2;
                default:        cass_route = 16'h0000;      // unused code
            endcase
        end
    endfunction

    // map a comparator ones count onto the raw scale
    // half reads just below mid
    // full window gives all ones
    function [15:0] cass_duty;
        input [WIN_LOG:0] ones;
        reg   [16:0]      wide;
        begin
            // count to top of 16 bits
            wide = {ones, {(16-WIN_LOG){1'b0}}};
            if (wide[16]) begin
                cass_duty = `CASS_RAW_FULL;                 // full duty
            end else if (wide[15:0] == 16'h8000) begin
                cass_duty = `CASS_RAW_MID;
            end else begin
                cass_duty = wide[15:0];
            end
        end
    endfunction

    // left-align narrower converter results into 16 bits
    // low bits read zero
    wire [RAW_W+15:0] iu_ext = {adc_iu_raw_i, 16'h0000};
    wire [RAW_W+15:0] iv_ext = {adc_iv_raw_i, 16'h0000};
    wire [15:0]       iu16   = iu_ext[RAW_W+15:RAW_W];
    wire [15:0]       iv16   = iv_ext[RAW_W+15:RAW_W];

    // fifo between converter engine and arithmetic
    // absorbs engine stalls
    wire [31:0] fifo_data;                      // {iv, iu}
    wire        fifo_valid;                     // pair available
    wire        take;                           // pair consumed this cycle

    // drain when output empty or being accepted
    // stalled set never overwritten
    assign take = fifo_valid && (!cur_valid_o || foc_ready_i);

    // one word is a U and V pair
    cass_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   ({iv16, iu16}),
        .in_valid_i  (adc_valid_i),
        .in_ready_o  (adc_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (take)
    );

    // comparator pin synchroniser
    // only stage two is read on
    reg cmp_meta_q;                             // first stage
    reg cmp_sync_q;                             // second stage

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // both stages to idle
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            // pin through two stages
            cmp_meta_q <= cmp_bit_i;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // comparator demodulator: count ones over a window
    // window of 2**WIN_LOG bits
    // count restarts per window
    reg [WIN_LOG-1:0] win_cnt_q;                // window position
    reg [WIN_LOG:0]   ones_q;                   // ones so far
    wire [WIN_LOG:0]  ones_d = ones_q + {{WIN_LOG{1'b0}}, cmp_sync_q};
    wire              win_end = &win_cnt_q;     // last bit of window

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // window restarts
            win_cnt_q <= {WIN_LOG{1'b0}};
            ones_q    <= {(WIN_LOG+1){1'b0}};
            cmp_raw_o <= `CASS_RST_CMP;
        end else begin
            win_cnt_q <= win_cnt_q + 1'b1;
            if (win_end) begin
                // window complete: publish and restart
                cmp_raw_o <= cass_duty(ones_d);
                ones_q    <= {(WIN_LOG+1){1'b0}};
            end else begin
                ones_q <= ones_d;
            end
        end
    end

    // raw selection from the fifo head
    // paths may share a source
    wire [15:0] raw0 = cass_pick(path0_source_sel_i, fifo_data[15:0], fifo_data[31:16],
                                 path0_sw_value_i, path1_sw_value_i, cmp_raw_o);
    wire [15:0] raw1 = cass_pick(path1_source_sel_i, fifo_data[15:0], fifo_data[31:16],
                                 path0_sw_value_i, path1_sw_value_i, cmp_raw_o);

    // per-path scaling
    // offsets and gains read live
    wire [16:0] sc0 = cass_scale(raw0, path0_offset_i, path0_gain_q8_8_i);
    wire [16:0] sc1 = cass_scale(raw1, path1_offset_i, path1_gain_q8_8_i);

    // kirchhoff: third = -(i0 + i1), only in three-phase mode
    // sum of clamped paths
    // two-phase drives zero
    wire [16:0] sum01  = {sc0[15], sc0[15:0]} + {sc1[15], sc1[15:0]};
    wire [17:0] neg01  = 18'h00000 - {sum01[16], sum01};
    wire [16:0] kirch  = cass_sat({{8{neg01[17]}}, neg01});
    wire [16:0] third  = three_phase_mode_i ? kirch : 17'h00000;

    // routed outputs
    // fields decoded alike
    wire [15:0] ux_d = cass_route(ux_route_sel_i, sc0[15:0], sc1[15:0], third[15:0]);
    wire [15:0] v_d  = cass_route(v_route_sel_i,  sc0[15:0], sc1[15:0], third[15:0]);
    wire [15:0] wy_d = cass_route(wy_route_sel_i, sc0[15:0], sc1[15:0], third[15:0]);

    // result registers, loaded once per pair taken from the fifo
    // a pair's results move together
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // all results clear
            adc_iu_rd_o             <= `CASS_RST_CUR;
            adc_iv_rd_o             <= `CASS_RST_CUR;
            path0_raw_sample_o      <= `CASS_RST_CUR;
            path1_raw_sample_o      <= `CASS_RST_CUR;
            path0_scaled_current_o  <= `CASS_RST_CUR;
            path1_scaled_current_o  <= `CASS_RST_CUR;
            derived_third_current_o <= `CASS_RST_CUR;
            phase_ux_current_o      <= `CASS_RST_CUR;
            phase_v_current_o       <= `CASS_RST_CUR;
            phase_wy_current_o      <= `CASS_RST_CUR;
            sat_flag_o              <= 1'b0;
        end else if (take) begin
            // readback of every channel as 16 bits
            adc_iu_rd_o             <= fifo_data[15:0];
            adc_iv_rd_o             <= fifo_data[31:16];
            path0_raw_sample_o      <= raw0;
            path1_raw_sample_o      <= raw1;
            path0_scaled_current_o  <= sc0[15:0];
            path1_scaled_current_o  <= sc1[15:0];
            derived_third_current_o <= third[15:0];
            phase_ux_current_o      <= ux_d;
            // V is idle in two-phase mode
            phase_v_current_o       <= three_phase_mode_i ? v_d : 16'h0000;
            phase_wy_current_o      <= wy_d;
            sat_flag_o              <= sc0[16] | sc1[16] | third[16];
        end
    end

    // output handshake towards control engine
    // stays high on back-to-back sets
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // nothing offered
            cur_valid_o <= 1'b0;
        end else if (take) begin
            cur_valid_o <= 1'b1;                            // new set loaded
        end else if (foc_ready_i) begin
            cur_valid_o <= 1'b0;                            // set consumed
        end
    end

    // a change applies to the next pair
    // offsets and gains are taken live; software sets them before use

endmodule // cass_top

`default_nettype wire

// ===== dv/cass_assertions.sv
// assertion checker for the current select, scale and route path
`default_nettype none

module cass_assertions (
    input wire logic        clk_i,                   // clock
    input wire logic        reset_i,                 // reset
    input wire logic        adc_valid_i,             // pair offered
    input wire logic        adc_ready_o,             // fifo room
    input wire logic        foc_ready_i,             // engine takes
    input wire logic        cur_valid_o,             // set offered
    input wire logic        three_phase_mode_i,      // mode
    input wire logic [15:0] path0_offset_i,          // offset 0
    input wire logic [15:0] path1_offset_i,          // offset 1
    input wire logic [15:0] path0_gain_q8_8_i,       // gain 0
    input wire logic [15:0] path1_gain_q8_8_i,       // gain 1
    input wire logic [1:0]  ux_route_sel_i,          // ux route
    input wire logic [1:0]  v_route_sel_i,           // v route
    input wire logic [1:0]  wy_route_sel_i,          // wy route
    input wire logic [15:0] path0_raw_sample_o,      // raw 0
    input wire logic [15:0] path1_raw_sample_o,      // raw 1
    input wire logic [15:0] path0_scaled_current_o,  // scaled 0
    input wire logic [15:0] path1_scaled_current_o,  // scaled 1
    input wire logic [15:0] derived_third_current_o, // third
    input wire logic [15:0] phase_ux_current_o,      // ux out
    input wire logic [15:0] phase_v_current_o,       // v out
    input wire logic [15:0] phase_wy_current_o       // wy out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // clamp to the signed 16-bit range
    function automatic logic [15:0] sat(input logic signed [35:0] x);
        sat = (x > 36'sh7FFF) ? 16'h7FFF : (x < -36'sh8000) ? 16'h8000 : x[15:0];
    endfunction
    // offset removal, q8.8 gain, floor shift
    function automatic logic [15:0] scl(input logic [15:0] r, o, g);
        scl = sat((($signed({1'b0, r}) - $signed({1'b0, o})) * $signed(g)) >>> 8);
    endfunction
    // route code to one of three currents
    function automatic logic [15:0] rt(input logic [1:0] s, input logic [15:0] a, b, c);
        rt = (s == 2'h1) ? b : (s == 2'h2) ? c : a;
    endfunction
    sequence load_s;  // set loaded at last edge, none offered before
        $rose(cur_valid_o);
    endsequence
    sequence push_s;  // pair taken by fifo
        adc_valid_i && adc_ready_o;
    endsequence
    sequence stall_s; // set held off by engine
        cur_valid_o && !foc_ready_i;
    endsequence
    ready_fill_a: assert property ($fell(adc_ready_o) |-> $past(adc_valid_i))
        else $error("fifo filled without a push");
    push_answer_a: assert property (push_s |-> ##[1:2] cur_valid_o)
        else $error("no current set after a push");
    stall_hold_a: assert property (stall_s |=> cur_valid_o && $stable(phase_ux_current_o) && $stable(phase_wy_current_o))
        else $error("stalled set changed");
    scale_pair_a: assert property (load_s |-> path0_scaled_current_o == scl(path0_raw_sample_o, $past(path0_offset_i),
        $past(path0_gain_q8_8_i)) && path1_scaled_current_o == scl(path1_raw_sample_o, $past(path1_offset_i),
        $past(path1_gain_q8_8_i))) else $error("scaled current wrong");
    kirchhoff_sum_a: assert property (load_s ##0 $past(three_phase_mode_i) |-> derived_third_current_o ==
        sat(-($signed(path0_scaled_current_o) + $signed(path1_scaled_current_o)))) else $error("third current wrong");
    two_phase_a: assert property (load_s ##0 !$past(three_phase_mode_i) |->
        phase_v_current_o == 16'h0000 && derived_third_current_o == 16'h0000) else $error("two-phase third or v set");
    route_uxwy_a: assert property (load_s |-> phase_ux_current_o == rt($past(ux_route_sel_i), path0_scaled_current_o,
        path1_scaled_current_o, derived_third_current_o) && phase_wy_current_o == rt($past(wy_route_sel_i),
        path0_scaled_current_o, path1_scaled_current_o, derived_third_current_o)) else $error("ux or wy route wrong");
    route_v_a: assert property (load_s ##0 $past(three_phase_mode_i) |-> phase_v_current_o ==
        rt($past(v_route_sel_i), path0_scaled_current_o, path1_scaled_current_o, derived_third_current_o))
        else $error("v route wrong");
    reset_clear_a: assert property ($fell(reset_i) |-> !cur_valid_o && adc_ready_o && phase_ux_current_o == 16'h0000)
        else $error("outputs not clear after reset");
endmodule // cass_assertions

bind cass_top cass_assertions chk (.clk_i, .reset_i, .adc_valid_i, .adc_ready_o, .foc_ready_i, .cur_valid_o,
    .three_phase_mode_i, .path0_offset_i, .path1_offset_i, .path0_gain_q8_8_i, .path1_gain_q8_8_i,
    .ux_route_sel_i, .v_route_sel_i, .wy_route_sel_i, .path0_raw_sample_o, .path1_raw_sample_o,
    .path0_scaled_current_o, .path1_scaled_current_o, .derived_third_current_o, .phase_ux_current_o,
    .phase_v_current_o, .phase_wy_current_o);
`default_nettype wire

// ===== dv/cass_foc_model.sv
// control engine model that takes and logs current sets
`default_nettype none

module cass_foc_model (
    input  wire logic        clk_i,   // system clock
    input  wire logic        reset_i, // async reset, high
    input  wire logic        stall_i, // hold off sets
    input  wire logic        three_i, // three-phase mode
    input  wire logic        valid_i, // set offered
    input  wire logic [15:0] ux_i,    // u / x current
    input  wire logic [15:0] v_i,     // v current
    input  wire logic [15:0] wy_i,    // w / y current
    output logic             ready_o  // set taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [47:0] got [$]; // sets taken, oldest first
    // ready is the inverse of the stall request
    assign ready_o = !stall_i;
    // log each set; v consumed in three-phase only
    always @(posedge clk_i) begin
        if (!reset_i && valid_i && ready_o) begin
            got.push_back({ux_i, three_i ? v_i : 16'h0000, wy_i});
        end
    end
endmodule // cass_foc_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the current select, scale and route path
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WL = 4; // short comparator window
    typedef struct packed {
        logic [2:0]  s0, s1;
        logic [15:0] iu, iv, o0, o1, g0, g1;
        logic        th;
        logic [1:0]  ux, v, wy;
        logic [15:0] e0, e1, eux, ev, ewy;
    } cass_row_t;
    cass_row_t   rows [6] = '{
        '{3'h0, 3'h1, 16'h8100, 16'h7F00, 16'h8000, 16'h8000, 16'h0100, 16'h0100, 1'b1, 2'h0, 2'h1, 2'h2,
          16'h0100, 16'hFF00, 16'h0100, 16'hFF00, 16'h0000},
        '{3'h2, 3'h3, 16'h0000, 16'h0000, 16'h8000, 16'h8000, 16'h0200, 16'h0080, 1'b1, 2'h2, 2'h0, 2'h1,
          16'h2000, 16'hF800, 16'hE800, 16'h2000, 16'hF800},
        '{3'h0, 3'h1, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'h0100, 16'h0100, 1'b1, 2'h0, 2'h1, 2'h2,
          16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h0001},
        '{3'h1, 3'h0, 16'h8010, 16'h8020, 16'h8000, 16'h8000, 16'hFF00, 16'hFF00, 1'b0, 2'h2, 2'h2, 2'h1,
          16'hFFE0, 16'hFFF0, 16'h0000, 16'h0000, 16'hFFF0},
        '{3'h0, 3'h1, 16'h8001, 16'h7FFF, 16'h8000, 16'h8000, 16'h0080, 16'h0080, 1'b1, 2'h3, 2'h1, 2'h0,
          16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000},
        '{3'h5, 3'h1, 16'h1234, 16'h1234, 16'h0000, 16'h0000, 16'h0100, 16'h0100, 1'b1, 2'h1, 2'h0, 2'h2,
          16'h0000, 16'h1234, 16'h1234, 16'h0000, 16'hEDCC}};
    logic        clk_i = 1'b0, reset_i = 1'b1, adc_valid = 1'b0, cmp_bit = 1'b0, stall = 1'b0, three = 1'b1;
    logic [2:0]  s0 = 3'h0, s1 = 3'h1;
    logic [15:0] iu = 16'h0000, iv = 16'h0000, sw0 = 16'h9000, sw1 = 16'h7000;
    logic [15:0] o0 = 16'h8000, o1 = 16'h8000, g0 = 16'h0100, g1 = 16'h0100;
    logic [1:0]  rux = 2'h0, rv = 2'h1, rwy = 2'h2;
    wire         adc_ready, cur_valid, foc_ready, sat;
    wire  [15:0] iu_rd, iv_rd, cmp_raw, r0, r1, c0, c1, c2, ux, v, wy;
    cass_row_t   r;                                          // row in use
    logic [47:0] q;                                          // logged set
    int          bad_count = 0, tests_run = 0, cyc = 0, duty = 0;
    int          duties [5] = '{0, 1, 2, 4, 3};              // ones per four bits
    logic [15:0] cmp_exp [5] = '{16'h0000, 16'h4000, 16'h7FFF, 16'hFFFF, 16'hC000};

    cass_top #(.WIN_LOG(WL)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .adc_iu_raw_i(iu), .adc_iv_raw_i(iv), .adc_valid_i(adc_valid),
        .adc_ready_o(adc_ready), .cmp_bit_i(cmp_bit), .path0_source_sel_i(s0), .path1_source_sel_i(s1),
        .path0_sw_value_i(sw0), .path1_sw_value_i(sw1), .path0_offset_i(o0), .path1_offset_i(o1),
        .path0_gain_q8_8_i(g0), .path1_gain_q8_8_i(g1), .three_phase_mode_i(three), .ux_route_sel_i(rux),
        .v_route_sel_i(rv), .wy_route_sel_i(rwy), .adc_iu_rd_o(iu_rd), .adc_iv_rd_o(iv_rd), .cmp_raw_o(cmp_raw),
        .path0_raw_sample_o(r0), .path1_raw_sample_o(r1), .path0_scaled_current_o(c0),
        .path1_scaled_current_o(c1), .derived_third_current_o(c2), .sat_flag_o(sat), .phase_ux_current_o(ux),
        .phase_v_current_o(v), .phase_wy_current_o(wy), .cur_valid_o(cur_valid), .foc_ready_i(foc_ready));
    cass_foc_model p (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .three_i(three), .valid_i(cur_valid),
        .ux_i(ux), .v_i(v), .wy_i(wy), .ready_o(foc_ready));

    always #50 clk_i = ~clk_i;
    // comparator bits at the chosen duty
    always @(posedge clk_i) begin
        #1;
        cmp_bit = (cyc % 4) < duty;
    end
    // cycle count and hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // offer a pair, hold until taken
    task automatic push(input logic [15:0] a, input logic [15:0] b);
        iu = a;
        iv = b;
        adc_valid = 1'b1;
        while (adc_ready !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
    endtask
    // wait for n logged sets
    task automatic wait_sets(input int n);
        while (p.got.size() < n) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    // reset and check cleared outputs
    task automatic do_reset();
        reset_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        chk({15'h0000, adc_ready}, 16'h0001);
        chk({15'h0000, cur_valid}, 16'h0000);
        chk(ux, 16'h0000);
        reset_i = 1'b0;
    endtask
    // expected raw for a source code
    function automatic logic [15:0] pick(input logic [2:0] s);
        pick = (s == 3'h0) ? iu : (s == 3'h1) ? iv : (s == 3'h2) ? sw0 : (s == 3'h3) ? sw1 : 16'h0000;
    endfunction
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        #1;
        do_reset();
        foreach (rows[k]) begin
            r = rows[k];
            {s0, s1} = r[188:183];
            {o0, o1, g0, g1, three, rux, rv, rwy} = r[150:80];
            push(r.iu, r.iv);
            adc_valid = 1'b0;
            wait_sets(1);
            q = p.got.pop_front();
            chk(r0, pick(r.s0));
            chk(r1, pick(r.s1));
            chk(iu_rd, r.iu);
            chk(iv_rd, r.iv);
            chk(c0, r.e0);
            chk(c1, r.e1);
            chk({15'h0000, sat}, {15'h0000, k == 2});
            chk(q[47:32], r.eux);
            chk(q[15:0], r.ewy);
            chk(v, r.ev);
        end
        // fill the fifo while the engine stalls, then drain in order
        stall = 1'b1;
        {s0, o0, g0, rux, rwy} = {3'h0, 16'h0000, 16'h0100, 2'h0, 2'h0};
        for (int k = 1; k <= 9; k++) begin
            push(16'(k), 16'h0000);
            chk({15'h0000, adc_ready}, {15'h0000, k < 9});
        end
        repeat (3) @(posedge clk_i);
        #1;
        adc_valid = 1'b0;
        stall = 1'b0;
        wait_sets(9);
        repeat (3) @(posedge clk_i);
        chk(16'(p.got.size()), 16'h0009);
        for (int k = 1; k <= 9; k++) begin
            q = p.got.pop_front();
            chk(q[47:32], 16'(k));
        end
        // comparator duty to raw value
        foreach (duties[k]) begin
            duty = duties[k];
            repeat (3 << WL) @(posedge clk_i);
            #1;
            chk(cmp_raw, cmp_exp[k]);
        end
        s0 = 3'h4;
        push(16'h0000, 16'h0000);
        adc_valid = 1'b0;
        wait_sets(1);
        chk(r0, 16'hC000);
        // reset in mid-run with sets pending
        stall = 1'b1;
        push(16'h0001, 16'h0002);
        push(16'h0003, 16'h0004);
        adc_valid = 1'b0;
        @(posedge clk_i);
        #1;
        do_reset();
        stall = 1'b0;
        s0 = 3'h0;
        p.got.delete();
        push(16'h0005, 16'h0000);
        adc_valid = 1'b0;
        wait_sets(1);
        chk(ux, 16'h0005);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
